// ==== rtl/gate_supervisor_pkg.sv ====
package gate_supervisor_pkg;
	// Register byte offsets (32-bit aligned words)
	localparam logic [7:0] OFS_BRIDGE_CTRL = 8'h00;
	localparam logic [7:0] OFS_HEATER_CTRL = 8'h04;
	localparam logic [7:0] OFS_MIRROR_CTRL = 8'h08;
	localparam logic [7:0] OFS_TIMING = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_FLAG_CLEAR = 8'h14;
	// Bridge control fields
	localparam int BRG_ENABLE_BIT = 0;
	localparam int BRG_SEL_A_BIT = 1;
	localparam int BRG_SEL_B_BIT = 2;
	localparam int BRG_HIGH_TH_BIT = 3;
	localparam int BRG_SLOPE_BIT = 4;
	localparam int BRG_DIR_BIT = 5;
	localparam int BRG_XDLY_LSB = 8;
	localparam int BRG_DSTH_LSB = 12;
	// Heater control fields
	localparam int HTR_ON_BIT = 0;
	localparam int HTR_PULLUP_BIT = 1;
	localparam int HTR_TH_LSB = 4;
	// Mirror control fields
	localparam int MIR_EN_BIT = 0;
	localparam int MIR_HIGH_BIT = 1;
	localparam int MIR_FAST_BIT = 2;
	localparam int MIR_CODE_LSB = 8;
	// Status fields
	localparam int ST_DS_LSB = 0;
	localparam int ST_HTR_DS_BIT = 4;
	localparam int ST_HTR_OPEN_BIT = 5;
	localparam int ST_MIR_HIGH_BIT = 6;
	localparam int ST_MIR_LOW_BIT = 7;
	localparam int ST_RESLOW_BIT = 8;
	localparam int ST_OFFDIAG_BIT = 9;
	// Reset values
	localparam logic [31:0] RST_BRIDGE_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_TIMING = 32'h0000_0009;
	// Time base: 1 us tick at 10 MHz
	localparam int CLK_HZ = 10_000_000;
	localparam int TICK_US = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	// Sink phase 32..64 us: pick 48 us in ticks
	localparam int SINK_MIN_US = 32;
	localparam int SINK_MAX_US = 64;
	localparam int SINK_TICKS = (SINK_MIN_US + SINK_MAX_US) / 2 / TICK_US;
	// Off-state open-load filter 2 ms
	localparam int OPEN_FILT_US = 2000;
	localparam int OPEN_FILT_TICKS = OPEN_FILT_US / TICK_US;
	// Mirror code span: 1.5 V full scale, 1.2 V clamp = 51/63
	localparam logic [5:0] MIRROR_CLAMP_CODE = 6'h33;
	typedef enum logic [1:0] {
		RL_IDLE,
		RL_SINK,
		RL_RESIST
	} reslow_state_t;
	typedef enum logic [1:0] {
		PW_ON,
		PW_HS_OFF,
		PW_LS_ON,
		PW_HS_WAIT
	} pwm_state_t;
endpackage

// ==== rtl/filter_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
// Qualifies a level: out follows in only after in has stayed stable for limit + 1 ticks
module filter_timer #(
	parameter int CW = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic enable,
	input wire logic level_in,
	input wire logic [CW-1:0] limit,
	output logic level_out
);
	logic [CW-1:0] count_ff;
	logic cand_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_ff <= '0;
			cand_ff <= 1'b0;
			level_out <= 1'b0;
		end else if (!enable) begin
			count_ff <= '0;
			cand_ff <= 1'b0;
			level_out <= 1'b0;
		end else if (level_in != cand_ff) begin
			cand_ff <= level_in;
			count_ff <= '0;
		end else if (level_out != cand_ff && tick) begin
			if (count_ff >= limit) begin
				level_out <= cand_ff;
			end else begin
				count_ff <= count_ff + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== rtl/gate_driver_supervisor.sv ====
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module gate_driver_supervisor
	import gate_supervisor_pkg::*;
#(
	parameter int FILT_W = 12,
	parameter int OPEN_FILT = OPEN_FILT_TICKS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic standby,
	input wire logic thermal_shutdown,
	input wire logic pump_low_fault,
	input wire logic serial_in_stuck,
	input wire logic bridge_pwm_in,
	input wire logic [3:0] ds_over,
	input wire logic [1:0] ds_below_sixth,
	input wire logic heater_ds_over,
	input wire logic heater_src_above,
	input wire logic mirror_above,
	input wire logic mirror_below,
	input wire logic mirror_near_target,
	input wire logic mirror_supply_switch,
	output logic [3:0] gate_on,
	output logic [3:0] gate_sink,
	output logic [3:0] gate_resistive,
	output logic gate_slope,
	output logic [2:0] bridge_ds_threshold,
	output logic heater_gate_on,
	output logic heater_resistive,
	output logic [1:0] heater_threshold_sel,
	output logic heater_pullup_en,
	output logic mirror_ctrl_en,
	output logic [5:0] mirror_dac_code,
	output logic mirror_fast_discharge
);
	// Gate index order: 0 high_a, 1 high_b, 2 low_a, 3 low_b
	logic [31:0] bridge_ctrl_ff, heater_ctrl_ff, mirror_ctrl_ff, timing_ff;
	logic [3:0] ds_flag_ff;
	logic heater_ds_flag_ff;
	logic tick_ff;
	logic [7:0] tick_cnt_ff;
	reslow_state_t rl_state_ff;
	logic [6:0] sink_cnt_ff;
	pwm_state_t pwm_state_ff;
	logic [3:0] xdly_cnt_ff;
	logic pwm_d_ff;
	logic [3:0] want_prev_ff;
	logic [3:0] ds_filt, diag_filt;
	logic heater_ds_filt, heater_open_filt, mir_high_filt, mir_low_filt;
	logic fail, offdiag, wr, rd, clr_wr;
	logic [3:0] want_gate;
	logic [1:0] diag_cmp;
	logic [31:0] status;
	logic [5:0] code_lim;

	function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw, input logic hit);
		wmask = hit ? nw : old;
	endfunction

	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign clr_wr = wr && paddr == OFS_FLAG_CLEAR;
	assign fail = thermal_shutdown || pump_low_fault || serial_in_stuck;
	assign offdiag = bridge_ctrl_ff[BRG_ENABLE_BIT] && (bridge_ctrl_ff[BRG_SEL_A_BIT] || bridge_ctrl_ff[BRG_SEL_B_BIT]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_ff <= 8'h00;
			tick_ff <= 1'b0;
		end else if (tick_cnt_ff >= timing_ff[7:0]) begin
			tick_cnt_ff <= 8'h00;
			tick_ff <= 1'b1;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 8'h01;
			tick_ff <= 1'b0;
		end
	end

	// APB slave, zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bridge_ctrl_ff <= RST_BRIDGE_CTRL;
			heater_ctrl_ff <= 32'h0000_0000;
			mirror_ctrl_ff <= 32'h0000_0000;
			timing_ff <= RST_TIMING;
		end else begin
			bridge_ctrl_ff <= wmask(bridge_ctrl_ff, pwdata, wr && paddr == OFS_BRIDGE_CTRL);
			heater_ctrl_ff <= wmask(heater_ctrl_ff, pwdata, wr && paddr == OFS_HEATER_CTRL);
			timing_ff <= wmask(timing_ff, pwdata, wr && paddr == OFS_TIMING);
			// supply switch off clears target code
			if (!mirror_supply_switch) begin
				mirror_ctrl_ff <= {mirror_ctrl_ff[31:14], 6'h00, mirror_ctrl_ff[7:0]};
			end else begin
				mirror_ctrl_ff <= wmask(mirror_ctrl_ff, pwdata, wr && paddr == OFS_MIRROR_CTRL);
			end
		end
	end

	always_comb begin
		status = 32'h0000_0000;
		status[ST_DS_LSB +: 4] = ds_flag_ff;
		status[ST_HTR_DS_BIT] = heater_ds_flag_ff;
		status[ST_HTR_OPEN_BIT] = heater_open_filt;
		status[ST_MIR_HIGH_BIT] = mir_high_filt;
		status[ST_MIR_LOW_BIT] = mir_low_filt;
		status[ST_RESLOW_BIT] = rl_state_ff != RL_IDLE;
		status[ST_OFFDIAG_BIT] = offdiag;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && paddr > OFS_FLAG_CLEAR;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					OFS_BRIDGE_CTRL: prdata <= bridge_ctrl_ff;
					OFS_HEATER_CTRL: prdata <= heater_ctrl_ff;
					OFS_MIRROR_CTRL: prdata <= mirror_ctrl_ff;
					OFS_TIMING: prdata <= timing_ff;
					OFS_STATUS: prdata <= status;
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// resistive-low sequencer: failure from idle goes through sink first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rl_state_ff <= RL_RESIST;
			sink_cnt_ff <= 7'h00;
		end else begin
			case (rl_state_ff)
				RL_IDLE: begin
					sink_cnt_ff <= 7'h00;
					if (fail) begin
						rl_state_ff <= RL_SINK;
					end else if (standby || offdiag) begin
						rl_state_ff <= RL_RESIST;
					end
				end
				RL_SINK: begin
					if (tick_ff) begin
						sink_cnt_ff <= sink_cnt_ff + 7'h01;
					end
					if (tick_ff && sink_cnt_ff >= 7'(SINK_TICKS - 1)) begin
						rl_state_ff <= RL_RESIST;
					end
				end
				RL_RESIST: begin
					if (!fail && !standby && !offdiag) begin
						rl_state_ff <= RL_IDLE;
					end
				end
				default: rl_state_ff <= RL_RESIST;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_state_ff <= PW_ON;
			xdly_cnt_ff <= 4'h0;
			pwm_d_ff <= 1'b0;
		end else begin
			pwm_d_ff <= bridge_pwm_in;
			if (tick_ff && xdly_cnt_ff != 4'h0) begin
				xdly_cnt_ff <= xdly_cnt_ff - 4'h1;
			end
			case (pwm_state_ff)
				PW_ON: begin
					if (!bridge_pwm_in) begin
						pwm_state_ff <= PW_HS_OFF;
						xdly_cnt_ff <= bridge_ctrl_ff[BRG_XDLY_LSB +: 4];
					end
				end
				PW_HS_OFF: begin
					if (bridge_pwm_in && !pwm_d_ff) begin
						pwm_state_ff <= PW_HS_WAIT;
						xdly_cnt_ff <= bridge_ctrl_ff[BRG_XDLY_LSB +: 4];
					end else if (xdly_cnt_ff == 4'h0) begin
						pwm_state_ff <= PW_LS_ON;
						xdly_cnt_ff <= bridge_ctrl_ff[BRG_XDLY_LSB +: 4];
					end
				end
				PW_LS_ON: begin
					if (bridge_pwm_in && !pwm_d_ff) begin
						pwm_state_ff <= PW_HS_WAIT;
						xdly_cnt_ff <= bridge_ctrl_ff[BRG_XDLY_LSB +: 4];
					end
				end
				PW_HS_WAIT: begin
					if (xdly_cnt_ff == 4'h0) begin
						pwm_state_ff <= PW_ON;
					end
				end
				default: pwm_state_ff <= PW_ON;
			endcase
		end
	end

	// Requested gates: direction picks diagonal; PWM gates the high side
	always_comb begin
		want_gate = 4'h0;
		if (bridge_ctrl_ff[BRG_ENABLE_BIT] && !offdiag && rl_state_ff == RL_IDLE) begin
			want_gate[bridge_ctrl_ff[BRG_DIR_BIT] ? 1 : 0] = pwm_state_ff == PW_ON;
			// Diagonal low side stays on; the other low side freewheels while high is locked off
			want_gate[bridge_ctrl_ff[BRG_DIR_BIT] ? 2 : 3] = 1'b1;
			want_gate[bridge_ctrl_ff[BRG_DIR_BIT] ? 3 : 2] = pwm_state_ff == PW_LS_ON;
		end
		want_gate = want_gate & ~ds_flag_ff;
	end

	// per-gate cross-conduction delay from switch-on request
	generate
		for (genvar g = 0; g < 4; g++) begin : g_gate
			logic [3:0] ccp_ff;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ccp_ff <= 4'h0;
					want_prev_ff[g] <= 1'b0;
					gate_on[g] <= 1'b0;
				end else begin
					want_prev_ff[g] <= want_gate[g];
					if (!want_gate[g]) begin
						gate_on[g] <= 1'b0;
					end else if (!want_prev_ff[g]) begin
						ccp_ff <= bridge_ctrl_ff[BRG_XDLY_LSB +: 4];
						gate_on[g] <= bridge_ctrl_ff[BRG_XDLY_LSB +: 4] == 4'h0;
					end else if (ccp_ff == 4'h0) begin
						gate_on[g] <= 1'b1;
					end else if (tick_ff) begin
						ccp_ff <= ccp_ff - 4'h1;
					end
				end
			end
			// on-state monitor only while driver is on
			filter_timer #(.CW(FILT_W)) u_ds_filt (
				.pclk(pclk),
				.presetn(presetn),
				.tick(tick_ff),
				.enable(gate_on[g]),
				.level_in(ds_over[g]),
				.limit(FILT_W'(timing_ff[19:16])),
				.level_out(ds_filt[g])
			);
		end
	endgenerate

	// high-threshold inverts both comparators; below one sixth
	assign diag_cmp = bridge_ctrl_ff[BRG_HIGH_TH_BIT] ? ~ds_below_sixth : ds_below_sixth;
	generate
		for (genvar d = 0; d < 2; d++) begin : g_diag
			filter_timer #(.CW(FILT_W)) u_diag_filt (
				.pclk(pclk),
				.presetn(presetn),
				.tick(tick_ff),
				.enable(offdiag),
				.level_in(diag_cmp[d]),
				.limit(FILT_W'(OPEN_FILT)),
				.level_out(diag_filt[d])
			);
		end
	endgenerate
	assign diag_filt[3:2] = 2'b00;

	// flag set on qualified overdrop; set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ds_flag_ff <= 4'h0;
		end else if (offdiag) begin
			// high-side flags held zero in off-state diagnosis
			ds_flag_ff <= {diag_filt[1:0] | (ds_flag_ff[3:2] & ~(clr_wr ? pwdata[3:2] : 2'b00)), 2'b00};
		end else begin
			ds_flag_ff <= ds_filt | (ds_flag_ff & ~(clr_wr ? pwdata[3:0] : 4'h0));
		end
	end

	// heater short trip, cleared by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			heater_ds_flag_ff <= 1'b0;
		end else begin
			heater_ds_flag_ff <= heater_ds_filt || (heater_ds_flag_ff && !(clr_wr && pwdata[ST_HTR_DS_BIT]));
		end
	end

	filter_timer #(.CW(FILT_W)) u_heat_ds (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick_ff),
		.enable(heater_gate_on),
		.level_in(heater_ds_over),
		.limit(FILT_W'(timing_ff[19:16])),
		.level_out(heater_ds_filt)
	);
	// open-load only with pull-up and gate off
	filter_timer #(.CW(FILT_W)) u_heat_ol (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick_ff),
		.enable(heater_ctrl_ff[HTR_PULLUP_BIT] && !heater_gate_on),
		.level_in(heater_src_above),
		.limit(FILT_W'(OPEN_FILT)),
		.level_out(heater_open_filt)
	);
	// unlatched mirror status after stable filter
	filter_timer #(.CW(FILT_W)) u_mir_hi (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick_ff),
		.enable(mirror_ctrl_ff[MIR_EN_BIT]),
		.level_in(mirror_above),
		.limit(FILT_W'(timing_ff[27:24])),
		.level_out(mir_high_filt)
	);
	filter_timer #(.CW(FILT_W)) u_mir_lo (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick_ff),
		.enable(mirror_ctrl_ff[MIR_EN_BIT]),
		.level_in(mirror_below),
		.limit(FILT_W'(timing_ff[27:24])),
		.level_out(mir_low_filt)
	);

	// clamp in low range keeps resolution
	assign code_lim = (!mirror_ctrl_ff[MIR_HIGH_BIT] && mirror_ctrl_ff[MIR_CODE_LSB +: 6] > MIRROR_CLAMP_CODE) ?
		MIRROR_CLAMP_CODE : mirror_ctrl_ff[MIR_CODE_LSB +: 6];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_sink <= 4'h0;
			gate_resistive <= 4'hf;
			gate_slope <= 1'b0;
			bridge_ds_threshold <= 3'h0;
			heater_gate_on <= 1'b0;
			heater_resistive <= 1'b1;
			heater_threshold_sel <= 2'h0;
			heater_pullup_en <= 1'b0;
			mirror_ctrl_en <= 1'b0;
			mirror_dac_code <= 6'h00;
			mirror_fast_discharge <= 1'b0;
		end else begin
			// sink then resistive on all bridge gates
			gate_sink <= {4{rl_state_ff == RL_SINK}};
			gate_resistive <= {4{rl_state_ff == RL_RESIST}};
			gate_slope <= bridge_ctrl_ff[BRG_SLOPE_BIT];
			bridge_ds_threshold <= bridge_ctrl_ff[BRG_DSTH_LSB +: 3];
			// heater bit; thermal shutdown forces resistive low
			heater_gate_on <= heater_ctrl_ff[HTR_ON_BIT] && !heater_ds_flag_ff && !heater_ds_filt && !thermal_shutdown;
			heater_resistive <= thermal_shutdown || standby;
			heater_threshold_sel <= heater_ctrl_ff[HTR_TH_LSB +: 2];
			heater_pullup_en <= heater_ctrl_ff[HTR_PULLUP_BIT];
			mirror_ctrl_en <= mirror_ctrl_ff[MIR_EN_BIT];
			mirror_dac_code <= mirror_ctrl_ff[MIR_EN_BIT] ? code_lim : 6'h00;
			mirror_fast_discharge <= mirror_ctrl_ff[MIR_FAST_BIT] && !mirror_near_target;
		end
	end

endmodule
`default_nettype wire

// ==== test/gds_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module gds_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic standby,
	input wire logic thermal_shutdown,
	input wire logic pump_low_fault,
	input wire logic serial_in_stuck,
	input wire logic [3:0] ds_over,
	input wire logic mirror_near_target,
	input wire logic mirror_supply_switch,
	input wire logic [3:0] gate_on,
	input wire logic [3:0] gate_sink,
	input wire logic [3:0] gate_resistive,
	input wire logic heater_gate_on,
	input wire logic [5:0] mirror_dac_code,
	input wire logic mirror_fast_discharge
);
	logic [9:0] sink_cnt_ff;
	logic fail;
	assign fail = thermal_shutdown | pump_low_fault | serial_in_stuck;
	// Saturates so a stuck sink phase cannot wrap into the legal window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) sink_cnt_ff <= 10'h000;
		else if (gate_sink == 4'h0) sink_cnt_ff <= 10'h000;
		else if (sink_cnt_ff != 10'h3ff) sink_cnt_ff <= sink_cnt_ff + 10'h001;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	apb_answer_a: assert property (psel && !penable |=> pready) else $error("pready late");
	pready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
	bad_addr_a: assert property (pready && pslverr |-> paddr > 8'h14) else $error("bad pslverr");
	standby_res_a: assert property (standby[*4] |-> gate_resistive == 4'hf && gate_on == 4'h0)
		else $error("standby not resistive");
	fault_off_a: assert property (fail[*4] |-> gate_on == 4'h0) else $error("gate on in fault");
	sink_len_a: assert property ($fell(|gate_sink) && fail |-> sink_cnt_ff >= 10'h12c && sink_cnt_ff <= 10'h294)
		else $error("sink length");
	sink_res_a: assert property ($fell(|gate_sink) && fail |-> ##[0:2] gate_resistive != 4'h0)
		else $error("no resistive after sink");
	tsd_heater_a: assert property (thermal_shutdown[*4] |-> !heater_gate_on) else $error("heater on in tsd");
	ds_trip_a: assert property (|(ds_over & gate_on) |-> ##[1:400] (ds_over & gate_on) == 4'h0)
		else $error("no trip");
	no_shoot_a: assert property (!(gate_on[0] && gate_on[2]) && !(gate_on[1] && gate_on[3]))
		else $error("cross conduction");
	mirror_zero_a: assert property ((!mirror_supply_switch)[*3] |-> mirror_dac_code == 6'h00)
		else $error("code not zeroed");
	fast_stop_a: assert property (mirror_near_target[*3] |-> !mirror_fast_discharge)
		else $error("fast discharge stuck");
endmodule
`default_nettype wire

// ==== test/load_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module load_model (
	input wire logic [3:0] gate_on,
	input wire logic heater_gate_on,
	input wire logic heater_pullup_en,
	input wire logic bridge_short,
	input wire logic heater_short,
	input wire logic heater_open,
	output logic [3:0] ds_over,
	output logic heater_ds_over,
	output logic heater_src_above
);
	assign ds_over = bridge_short ? gate_on : 4'h0;
	assign heater_ds_over = heater_short & heater_gate_on;
	assign heater_src_above = heater_open & heater_pullup_en & ~heater_gate_on;
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import gate_supervisor_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic standby = 1'b0, thermal_shutdown = 1'b0, pump_low_fault = 1'b0, serial_in_stuck = 1'b0;
	logic bridge_pwm_in = 1'b0, mirror_above = 1'b0, mirror_below = 1'b0, mirror_near_target = 1'b0;
	logic mirror_supply_switch = 1'b1, bridge_short = 1'b0, heater_short = 1'b0, heater_open = 1'b0;
	logic [1:0] ds_below_sixth = 2'b00, heater_threshold_sel;
	logic pready, pslverr, rerr, gate_slope, heater_gate_on, heater_resistive, heater_pullup_en;
	logic mirror_ctrl_en, mirror_fast_discharge, heater_ds_over, heater_src_above;
	logic [3:0] gate_on, gate_sink, gate_resistive, ds_over;
	logic [2:0] bridge_ds_threshold;
	logic [5:0] mirror_dac_code;
	int err_count = 0, n_tests = 0, n;
	always #50 pclk = ~pclk;
	// Short open-load filter keeps the run brief
	gate_driver_supervisor #(.OPEN_FILT(20)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .standby(standby), .thermal_shutdown(thermal_shutdown),
		.pump_low_fault(pump_low_fault), .serial_in_stuck(serial_in_stuck), .bridge_pwm_in(bridge_pwm_in),
		.ds_over(ds_over), .ds_below_sixth(ds_below_sixth), .heater_ds_over(heater_ds_over),
		.heater_src_above(heater_src_above), .mirror_above(mirror_above), .mirror_below(mirror_below),
		.mirror_near_target(mirror_near_target), .mirror_supply_switch(mirror_supply_switch),
		.gate_on(gate_on), .gate_sink(gate_sink), .gate_resistive(gate_resistive), .gate_slope(gate_slope),
		.bridge_ds_threshold(bridge_ds_threshold), .heater_gate_on(heater_gate_on),
		.heater_resistive(heater_resistive), .heater_threshold_sel(heater_threshold_sel),
		.heater_pullup_en(heater_pullup_en), .mirror_ctrl_en(mirror_ctrl_en),
		.mirror_dac_code(mirror_dac_code), .mirror_fast_discharge(mirror_fast_discharge));
	load_model loads (.gate_on(gate_on), .heater_gate_on(heater_gate_on), .heater_pullup_en(heater_pullup_en),
		.bridge_short(bridge_short), .heater_short(heater_short), .heater_open(heater_open),
		.ds_over(ds_over), .heater_ds_over(heater_ds_over), .heater_src_above(heater_src_above));
	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 20) chk(0, 1, "no pready");
	endtask
	task status(input logic [31:0] mask, input logic [31:0] exp, input string msg);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rdat & mask, exp, msg);
	endtask
	task t_regs;
		apb(1'b0, OFS_TIMING, 32'h0);
		chk(rdat, RST_TIMING, "timing reset");
		apb(1'b0, OFS_BRIDGE_CTRL, 32'h0);
		chk(rdat, RST_BRIDGE_CTRL, "bridge reset");
		apb(1'b1, 8'h18, 32'hffff_ffff);
		chk(rerr, 1'b1, "unmapped write");
		apb(1'b0, 8'h18, 32'h0);
		chk(rerr, 1'b1, "unmapped read error");
		chk(rdat, 32'h0, "unmapped read");
		apb(1'b1, OFS_STATUS, 32'hffff_ffff);
		status(32'hff, 32'h0, "status read only");
	endtask
	task t_faults;
		int k, c;
		logic s;
		apb(1'b1, OFS_BRIDGE_CTRL, 32'h10);
		for (k = 0; k < 4; k++) begin
			{serial_in_stuck, pump_low_fault, thermal_shutdown, standby} <= 4'h1 << k;
			c = 0;
			s = 1'b0;
			repeat (3) @(posedge pclk);
			for (n = 0; n < 1000 && gate_sink !== 4'h0; n++) begin
				@(posedge pclk);
				c++;
				if (gate_slope === 1'b1) s = 1'b1;
			end
			repeat (5) @(posedge pclk);
			chk(gate_resistive, 4'hf, "resistive mode");
			chk(gate_on, 4'h0, "gates off");
			if (k > 0) chk(c >= 300 && c <= 640, 1, "sink length");
			if (k > 0) chk(s, 1'b1, "slope in sink");
			if (k == 1) chk(heater_resistive, 1'b1, "heater resistive");
			{serial_in_stuck, pump_low_fault, thermal_shutdown, standby} <= 4'h0;
			repeat (20) @(posedge pclk);
		end
	endtask
	task t_bridge;
		logic [3:0] g;
		bridge_pwm_in <= 1'b1;
		apb(1'b1, OFS_BRIDGE_CTRL, 32'h5321);
		for (n = 0; n < 500 && gate_on === 4'h0; n++) @(posedge pclk);
		g = gate_on;
		chk(g != 4'h0, 1, "bridge on");
		chk(g, 4'h6, "diagonal pair");
		chk(n >= 20 && n <= 40, 1, "cross delay");
		chk(bridge_ds_threshold, 3'h5, "ds threshold");
		bridge_pwm_in <= 1'b0;
		for (n = 0; n < 500 && gate_on !== 4'hc; n++) @(posedge pclk);
		chk(gate_on[1:0], 2'b00, "high side off");
		chk(gate_on[3:2], 2'b11, "low side on");
		bridge_pwm_in <= 1'b1;
		for (n = 0; n < 500 && gate_on !== g; n++) @(posedge pclk);
		chk(gate_on, g, "high side back");
		bridge_short <= 1'b1;
		for (n = 0; n < 500 && gate_on !== 4'h0; n++) @(posedge pclk);
		chk(gate_on, 4'h0, "trip off");
		status(32'hf, g, "ds flags");
		bridge_short <= 1'b0;
		repeat (50) @(posedge pclk);
		chk(gate_on, 4'h0, "stays off");
		apb(1'b1, OFS_FLAG_CLEAR, 32'hf);
		for (n = 0; n < 500 && gate_on !== g; n++) @(posedge pclk);
		chk(gate_on, g, "on after clear");
		apb(1'b1, OFS_BRIDGE_CTRL, 32'h0);
	endtask
	task t_offdiag;
		apb(1'b1, OFS_BRIDGE_CTRL, 32'h3);
		ds_below_sixth <= 2'b11;
		repeat (100) @(posedge pclk);
		chk(gate_resistive, 4'hf, "offdiag resistive");
		status(32'hf, 32'h0, "filter pending");
		repeat (200) @(posedge pclk);
		status(32'hf, 32'hc, "ground short");
		ds_below_sixth <= 2'b00;
		repeat (300) @(posedge pclk);
		apb(1'b1, OFS_FLAG_CLEAR, 32'hf);
		status(32'hf, 32'h0, "no short");
		apb(1'b1, OFS_BRIDGE_CTRL, 32'hb);
		repeat (300) @(posedge pclk);
		status(32'hf, 32'hc, "inverted");
		apb(1'b1, OFS_BRIDGE_CTRL, 32'h0);
		apb(1'b1, OFS_FLAG_CLEAR, 32'hf);
	endtask
	task t_heater;
		apb(1'b1, OFS_HEATER_CTRL, 32'h21);
		for (n = 0; n < 20 && heater_gate_on !== 1'b1; n++) @(posedge pclk);
		chk(heater_gate_on, 1'b1, "heater on");
		chk(heater_threshold_sel, 2'h2, "heater threshold");
		heater_short <= 1'b1;
		for (n = 0; n < 500 && heater_gate_on !== 1'b0; n++) @(posedge pclk);
		chk(heater_gate_on, 1'b0, "heater trip");
		status(32'h10, 32'h10, "heater flag");
		heater_short <= 1'b0;
		repeat (50) @(posedge pclk);
		chk(heater_gate_on, 1'b0, "heater stays off");
		apb(1'b1, OFS_FLAG_CLEAR, 32'h10);
		for (n = 0; n < 20 && heater_gate_on !== 1'b1; n++) @(posedge pclk);
		chk(heater_gate_on, 1'b1, "heater back");
		apb(1'b1, OFS_HEATER_CTRL, 32'h2);
		heater_open <= 1'b1;
		repeat (400) @(posedge pclk);
		chk(heater_pullup_en, 1'b1, "pull-up");
		status(32'h20, 32'h20, "open load");
		heater_open <= 1'b0;
		apb(1'b1, OFS_HEATER_CTRL, 32'h0);
	endtask
	task t_mirror;
		apb(1'b1, OFS_MIRROR_CTRL, 32'h3f01);
		repeat (3) @(posedge pclk);
		chk({mirror_ctrl_en, mirror_dac_code}, {1'b1, MIRROR_CLAMP_CODE}, "clamp");
		apb(1'b1, OFS_MIRROR_CTRL, 32'h3f07);
		repeat (3) @(posedge pclk);
		chk(mirror_dac_code, 6'h3f, "full code");
		chk(mirror_fast_discharge, 1'b1, "fast on");
		mirror_near_target <= 1'b1;
		repeat (5) @(posedge pclk);
		chk(mirror_fast_discharge, 1'b0, "fast off");
		mirror_near_target <= 1'b0;
		mirror_above <= 1'b1;
		repeat (50) @(posedge pclk);
		status(32'hc0, 32'h40, "too high");
		mirror_above <= 1'b0;
		mirror_below <= 1'b1;
		repeat (50) @(posedge pclk);
		status(32'hc0, 32'h80, "not reached");
		mirror_below <= 1'b0;
		mirror_supply_switch <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(mirror_dac_code, 6'h00, "code forced");
		mirror_supply_switch <= 1'b1;
		apb(1'b0, OFS_MIRROR_CTRL, 32'h0);
		chk(rdat[13:8], 6'h00, "needs reprogram");
	endtask
	task final_report;
		$display("Checks %0d, errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_faults();
		t_bridge();
		t_offdiag();
		t_heater();
		t_mirror();
		final_report();
	end
	// Whole sequence needs roughly 3.5k cycles
	initial begin
		#(30000 * 100);
		err_count++;
		final_report();
	end
endmodule
bind gate_driver_supervisor gds_assertions chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .standby(standby),
	.thermal_shutdown(thermal_shutdown), .pump_low_fault(pump_low_fault), .serial_in_stuck(serial_in_stuck),
	.ds_over(ds_over), .mirror_near_target(mirror_near_target), .mirror_supply_switch(mirror_supply_switch),
	.gate_on(gate_on), .gate_sink(gate_sink), .gate_resistive(gate_resistive), .heater_gate_on(heater_gate_on),
	.mirror_dac_code(mirror_dac_code), .mirror_fast_discharge(mirror_fast_discharge));
`default_nettype wire
